// ---- design/tcwl_framer.sv ----
`timescale 1ns/10ps
module tcwl_framer (
  input wire logic [3:0] i_word_id,
  input wire logic i_inhibit,
  input wire logic [47:16] i_data,
  output logic [47:0] o_frame
);
  logic [47:0] raw;
  logic [2:0] run;

  always_comb
  begin
    raw = '0;
    raw[tcwl_pkg::SYNC_BITS-1:0] = tcwl_pkg::SYNC_CODE;
    raw[tcwl_pkg::BIT_INHIBIT] = i_inhibit;
    raw[tcwl_pkg::ID_LSB +: 4] = i_word_id;
    raw[47:tcwl_pkg::DATA_LSB] = i_data;
  end

  // Forced zero insertion.
  // A fifth one in a row is forced to zero so that nothing mimics sync.
  always_comb
  begin
    o_frame = raw;
    run = 3'h0;
    for (int i = tcwl_pkg::RUN_START; i < tcwl_pkg::FRAME_BITS; i++)
    begin
      if (raw[i] && run == 3'(tcwl_pkg::RUN_MAX))
      begin
        o_frame[i] = 1'b0;
        run = 3'h0;
      end
      else if (raw[i])
      begin
        run = run + 3'h1;
      end
      else
      begin
        run = 3'h0;
      end
    end
  end
endmodule : tcwl_framer

// ---- design/tcwl_link.sv ----
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Mode bits 34 and 33: 00 operate, 01 mute, 10 transmit.
// - Mode bit 36 is one for high power, zero for low.
// - Bit 25 is -6 dB, bit 27 is -20 dB, none is suppressed.
// - Bit 28 lower, 29 independent, 31 keyed; none is upper sideband.
// - Mode bits 26 and 30 are always zero.
// - Keyed mode sets 28 and 31; reduced carrier AM sets only 25.
// - Earthed user inputs appear in mode bits 44 to 47.
// - Word 8 is left to external gear; returned word 9 flags operator addressing.
// - Check status freezes controls and sends words in plain order.
// - Internal 19.2 kHz clock, overridden by an external master clock.
// - Separate circuits for data out, data in, clock out and clocks in.
// - Preamble bits 12 to 15 carry the word identity.
// - Forced zeros stop five ones in a row outside sync.
module tcwl_link #(
  parameter int EXT_LOSS_CYC = tcwl_pkg::EXT_LOSS_CYC
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_master_clk,
  input wire logic i_rev_clk,
  input wire logic i_rev_data,
  output logic o_ctl_clk,
  output logic o_ctl_data,
  input wire logic [3:0] i_user_earth_n,
  output logic [3:0] o_rev_user_n,
  output logic o_line_fault
);
  localparam int LW = $clog2(EXT_LOSS_CYC + 1);
  localparam int IW = $clog2(tcwl_pkg::INT_HALF_CYC + 1);
  typedef enum logic {RX_HUNT, RX_BODY} tcwl_rx_e;

  logic ext_lvl;
  logic ext_rise;
  logic ext_fall;
  logic rclk_rise;
  logic rdat_lvl;
  logic [3:0] user_n;
  logic ext_active;
  logic [LW-1:0] loss_cnt;
  logic [IW-1:0] int_cnt;
  logic int_clk;
  logic bit_clk;
  logic next_bit_clk;
  logic bit_fall;
  logic ack;
  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [9:0] mode_reg;
  logic [21:0] freq_reg;
  logic check;
  logic new_mode;
  logic [47:16] mode_data;
  logic [47:16] next_data;
  logic [3:0] rt_word;
  logic [3:0] rt_next;
  logic [3:0] next_word;
  logic [3:0] tx_word;
  logic [5:0] bit_cnt;
  logic second;
  logic load;
  logic [47:0] frame_q;
  logic [47:0] next_frame;
  tcwl_rx_e rx_state;
  logic [5:0] rx_cnt;
  logic [47:0] shreg;
  logic [47:0] next_shreg;
  logic rx_done;
  logic [3:0] rx_wid;
  logic op_addr;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Master clock in on its own circuit.
  tcwl_sync u_ext (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_master_clk),
    .o_level(ext_lvl), .o_rise(ext_rise), .o_fall(ext_fall)
  );
  // Revertive clock and data on separate circuits.
  tcwl_sync u_rclk (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_rev_clk),
    .o_level(), .o_rise(rclk_rise), .o_fall()
  );
  tcwl_sync u_rdat (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_rev_data),
    .o_level(rdat_lvl), .o_rise(), .o_fall()
  );
  for (genvar g = 0; g < 4; g++)
  begin : g_user
    tcwl_sync #(.RST_VAL(1'b1)) u_user (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_user_earth_n[g]),
      .o_level(user_n[g]), .o_rise(), .o_fall()
    );
  end

  // ----------------------------------------
  // Bit clock source
  // ----------------------------------------
  // External clock presence detection.
  // Presence is judged by edges; a clock slower than half the floor counts as lost.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      loss_cnt <= '0;
      ext_active <= 1'b0;
    end
    else if (ext_rise || ext_fall)
    begin
      loss_cnt <= '0;
      ext_active <= 1'b1;
    end
    else if (loss_cnt == LW'(EXT_LOSS_CYC - 1))
    begin
      ext_active <= 1'b0;
    end
    else
    begin
      loss_cnt <= loss_cnt + LW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      int_cnt <= '0;
      int_clk <= 1'b0;
    end
    else if (int_cnt == IW'(tcwl_pkg::INT_HALF_CYC - 1))
    begin
      int_cnt <= '0;
      int_clk <= ~int_clk;
    end
    else
    begin
      int_cnt <= int_cnt + IW'(1);
    end
  end

  assign next_bit_clk = ext_active ? ext_lvl : int_clk;
  assign bit_fall = bit_clk & ~next_bit_clk;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_clk <= 1'b0;
    end
    else
    begin
      bit_clk <= next_bit_clk;
    end
  end

  assign o_ctl_clk = bit_clk;

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  assign o_waitrequest = (i_read | i_write) & ~ack;
  assign wr_en = i_write & ack;
  for (genvar b = 0; b < 4; b++)
  begin : g_mask
    assign wmask[8*b +: 8] = {8{i_byteenable[b]}};
  end

  always_comb
  begin
    rd_mux = '0;
    case (i_address)
      tcwl_pkg::REG_MODE: rd_mux[tcwl_pkg::MODE_W-1:0] = mode_reg;
      tcwl_pkg::REG_FREQ: rd_mux[tcwl_pkg::FREQ_W-1:0] = freq_reg;
      tcwl_pkg::REG_CTRL: rd_mux[0] = check;
      tcwl_pkg::REG_STAT:
      begin
        rd_mux[tcwl_pkg::SF_FAULT] = o_line_fault;
        rd_mux[tcwl_pkg::SF_EXT] = ext_active;
        rd_mux[tcwl_pkg::SF_OPADDR] = op_addr;
        rd_mux[tcwl_pkg::SF_USER +: 4] = ~o_rev_user_n;
        rd_mux[tcwl_pkg::SF_WID +: 4] = rx_wid;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ack <= 1'b0;
      o_readdata <= '0;
    end
    else
    begin
      ack <= (i_read | i_write) & ~ack;
      if (i_read && !ack)
      begin
        o_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_reg <= tcwl_pkg::MODE_RST;
      freq_reg <= tcwl_pkg::FREQ_RST;
      check <= 1'b0;
    end
    else if (wr_en)
    begin
      if (i_address == tcwl_pkg::REG_MODE && !check)
      begin
        mode_reg <= (mode_reg & ~wmask[9:0]) | (i_writedata[9:0] & wmask[9:0]);
      end
      if (i_address == tcwl_pkg::REG_FREQ && !check)
      begin
        freq_reg <= (freq_reg & ~wmask[21:0]) | (i_writedata[21:0] & wmask[21:0]);
      end
      if (i_address == tcwl_pkg::REG_CTRL && i_byteenable[0])
      begin
        check <= i_writedata[0];
      end
    end
  end

  // ----------------------------------------
  // Mode word encoding
  // ----------------------------------------
  always_comb
  begin
    mode_data = '0;
    mode_data[tcwl_pkg::BIT_STBY] = mode_reg[tcwl_pkg::MF_STBY];
    mode_data[tcwl_pkg::BIT_EHT] = mode_reg[tcwl_pkg::MF_EHT];
    mode_data[tcwl_pkg::BIT_RESET] = mode_reg[tcwl_pkg::MF_RESET];
    mode_data[tcwl_pkg::BIT_AUTO] = mode_reg[tcwl_pkg::MF_AUTO];
    case (mode_reg[tcwl_pkg::MF_STATE +: 2])
      tcwl_pkg::TX_MUTE: mode_data[tcwl_pkg::BIT_ST_LO +: 2] = 2'h1;
      tcwl_pkg::TX_TRANSMIT: mode_data[tcwl_pkg::BIT_ST_LO +: 2] = 2'h2;
      default: mode_data[tcwl_pkg::BIT_ST_LO +: 2] = 2'h0;
    endcase
    mode_data[tcwl_pkg::BIT_POWER] = mode_reg[tcwl_pkg::MF_POWER];
    // Carrier and sideband.
    // Bits 26 and 30 are never set here, which by construction.
    case (mode_reg[tcwl_pkg::MF_SEL +: 3])
      tcwl_pkg::MS_KEYED:
      begin
        mode_data[tcwl_pkg::BIT_LSB] = 1'b1;
        mode_data[tcwl_pkg::BIT_KEY] = 1'b1;
      end
      tcwl_pkg::MS_AM_REDUCED: mode_data[tcwl_pkg::BIT_CAR6] = 1'b1;
      tcwl_pkg::MS_USB20: mode_data[tcwl_pkg::BIT_CAR20] = 1'b1;
      tcwl_pkg::MS_LSB20:
      begin
        mode_data[tcwl_pkg::BIT_LSB] = 1'b1;
        mode_data[tcwl_pkg::BIT_CAR20] = 1'b1;
      end
      tcwl_pkg::MS_LSB_SUPP: mode_data[tcwl_pkg::BIT_LSB] = 1'b1;
      tcwl_pkg::MS_INDEP20:
      begin
        mode_data[tcwl_pkg::BIT_INDEP] = 1'b1;
        mode_data[tcwl_pkg::BIT_CAR20] = 1'b1;
      end
      tcwl_pkg::MS_INDEP_SUPP: mode_data[tcwl_pkg::BIT_INDEP] = 1'b1;
      default: mode_data[tcwl_pkg::BIT_LSB] = 1'b0;
    endcase
    mode_data[tcwl_pkg::USER_LSB +: 4] = ~user_n;
  end

  // ----------------------------------------
  // Forward word sequencer
  // ----------------------------------------
  // Word 8 is never generated here.
  always_comb
  begin
    case (rt_word)
      tcwl_pkg::WORD_MON: rt_next = tcwl_pkg::WORD_FREQ;
      tcwl_pkg::WORD_FREQ: rt_next = tcwl_pkg::WORD_MODE;
      default: rt_next = tcwl_pkg::WORD_MON;
    endcase
  end

  assign next_word = (new_mode && !check) ? tcwl_pkg::WORD_MODE : rt_next;
  assign load = bit_fall && bit_cnt == 6'(tcwl_pkg::FRAME_BITS - 1) && second;

  always_comb
  begin
    next_data = '0;
    case (next_word)
      tcwl_pkg::WORD_FREQ: next_data[tcwl_pkg::FREQ_LSB +: tcwl_pkg::FREQ_W] = freq_reg;
      tcwl_pkg::WORD_MODE: next_data = mode_data;
      default: next_data = '0;
    endcase
  end

  tcwl_framer u_framer (
    .i_word_id(next_word),
    .i_inhibit(check),
    .i_data(next_data),
    .o_frame(next_frame)
  );

  // Mode changes are latched so they jump the routine queue after this pair.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      new_mode <= 1'b0;
    end
    else if (wr_en && i_address == tcwl_pkg::REG_MODE && !check)
    begin
      new_mode <= 1'b1;
    end
    else if (load && next_word == tcwl_pkg::WORD_MODE)
    begin
      new_mode <= 1'b0;
    end
  end

  // Each frame goes out twice so the far end can compare the pair.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_cnt <= 6'(tcwl_pkg::FRAME_BITS - 1);
      second <= 1'b1;
      frame_q <= '0;
      tx_word <= tcwl_pkg::WORD_MODE;
      rt_word <= tcwl_pkg::WORD_MODE;
      o_ctl_data <= 1'b0;
    end
    else if (bit_fall)
    begin
      o_ctl_data <= frame_q[bit_cnt];
      if (bit_cnt != 6'(tcwl_pkg::FRAME_BITS - 1))
      begin
        bit_cnt <= bit_cnt + 6'h1;
      end
      else
      begin
        bit_cnt <= '0;
        second <= ~second;
        if (second)
        begin
          frame_q <= next_frame;
          tx_word <= next_word;
          if (!(new_mode && !check) || rt_next == tcwl_pkg::WORD_MODE)
          begin
            rt_word <= rt_next;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Revertive receiver
  // ----------------------------------------
  assign next_shreg = {rdat_lvl, shreg[47:1]};
  assign rx_done = rclk_rise && rx_state == RX_BODY
                   && rx_cnt == 6'(tcwl_pkg::FRAME_BITS - 1);

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      shreg <= '0;
      rx_state <= RX_HUNT;
      rx_cnt <= '0;
    end
    else if (rclk_rise)
    begin
      shreg <= next_shreg;
      case (rx_state)
        RX_HUNT:
        begin
          if (next_shreg[47:42] == tcwl_pkg::SYNC_CODE)
          begin
            rx_state <= RX_BODY;
            rx_cnt <= 6'(tcwl_pkg::SYNC_BITS);
          end
        end
        RX_BODY:
        begin
          rx_cnt <= rx_cnt + 6'h1;
          if (rx_done)
          begin
            rx_state <= RX_HUNT;
          end
        end
        default: rx_state <= RX_HUNT;
      endcase
    end
  end

  // Returned fault bit lights line fault.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_line_fault <= 1'b0;
      o_rev_user_n <= 4'hf;
      rx_wid <= '0;
    end
    else if (rx_done)
    begin
      rx_wid <= next_shreg[tcwl_pkg::ID_LSB +: 4];
      if (next_shreg[tcwl_pkg::ID_LSB +: 4] == tcwl_pkg::WORD_MON)
      begin
        o_line_fault <= next_shreg[tcwl_pkg::BIT_FAULT];
        o_rev_user_n <= ~next_shreg[tcwl_pkg::REV_USER_LSB +: 4];
      end
    end
  end

  // Operator addressing flag.
  // A returned word 9 in the clearing cycle keeps the flag set.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      op_addr <= 1'b0;
    end
    else if (rx_done && next_shreg[tcwl_pkg::ID_LSB +: 4] == tcwl_pkg::WORD_OPADDR)
    begin
      op_addr <= 1'b1;
    end
    else if (wr_en && i_address == tcwl_pkg::REG_STAT && i_byteenable[0]
             && i_writedata[tcwl_pkg::SF_OPADDR])
    begin
      op_addr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_state_bits: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    mode_reg[1:0] == 2'h2 |-> mode_data[34:33] == 2'h2)
    else $error("transmit state not encoded as 10");
  a_power_bit: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    load && next_word == 4'h3 |=> frame_q[36] == $past(mode_reg[2]))
    else $error("power bit does not follow selection");
  a_carrier_supp: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    mode_reg[5:3] inside {3'h3, 3'h5, 3'h7} |-> mode_data[27:25] == 3'h0)
    else $error("suppressed carrier has level bits set");
  a_sideband_indep: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    mode_reg[5:3] == 3'h7 |-> mode_data[31:28] == 4'h2)
    else $error("independent sideband bits wrong");
  a_fixed_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    tx_word == 4'h3 |-> !frame_q[26] && !frame_q[30])
    else $error("bit 26 or 30 set in a sent frame");
  a_keyed_mode: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    mode_reg[5:3] == 3'h0 |-> mode_data[31:25] == 7'h48)
    else $error("keyed mode encoding wrong");
  a_user_lines: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    load && next_word == 4'h3 |=> frame_q[47:44] == ~$past(user_n))
    else $error("user lines not carried in word 3");
  a_op_addr: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    rx_done && next_shreg[15:12] == 4'h9 |=> op_addr)
    else $error("returned word 9 not flagged");
  a_check_freeze: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    check |=> $stable(mode_reg) && $stable(freq_reg))
    else $error("controls changed in check status");
  a_inhibit_bit: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    load |=> frame_q[8] == $past(check))
    else $error("inhibit bit does not follow check status");
  a_ext_takeover: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ext_rise |=> ext_active ##1 (o_ctl_clk == $past(ext_lvl)))
    else $error("external clock did not take over");
  a_word_ident: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    load |=> frame_q[15:12] == $past(next_word) && frame_q[5:0] == 6'h3e)
    else $error("preamble identity or sync wrong");
  a_run_limit: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    load |=> (frame_q[10:6] != 5'h1f && frame_q[20:16] != 5'h1f
              && frame_q[28:24] != 5'h1f && frame_q[45:41] != 5'h1f))
    else $error("five ones in a row outside sync");
endmodule : tcwl_link

// ---- design/tcwl_pkg.sv ----
package tcwl_pkg;
  // ----------------------------------------
  // Clocking and link timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int INT_CLK_HZ = 19_200;
  localparam int INT_HALF_CYC = CLK_HZ / (2 * INT_CLK_HZ);
  localparam int EXT_MIN_HZ = 100;
  localparam int EXT_MAX_HZ = 20_000;
  localparam int EXT_LOSS_CYC = CLK_HZ / EXT_MIN_HZ;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 48;
  localparam int DATA_LSB = 16;
  localparam int SYNC_BITS = 6;
  localparam logic [5:0] SYNC_CODE = 6'h3e;
  localparam int RUN_START = 6;
  localparam int RUN_MAX = 4;
  localparam int BIT_INHIBIT = 8;
  localparam int BIT_RETMON = 9;
  localparam int ID_LSB = 12;
  localparam int BIT_STBY = 16;
  localparam int BIT_EHT = 17;
  localparam int BIT_RESET = 18;
  localparam int FREQ_LSB = 24;
  localparam int BIT_CAR6 = 25;
  localparam int BIT_CAR10 = 26;
  localparam int BIT_CAR20 = 27;
  localparam int BIT_LSB = 28;
  localparam int BIT_INDEP = 29;
  localparam int BIT_TTY = 30;
  localparam int BIT_KEY = 31;
  localparam int BIT_ST_LO = 33;
  localparam int BIT_FAULT = 34;
  localparam int BIT_POWER = 36;
  localparam int BIT_AUTO = 37;
  localparam int USER_LSB = 44;
  localparam int REV_USER_LSB = 16;
  localparam logic [3:0] WORD_MON = 4'h0;
  localparam logic [3:0] WORD_FREQ = 4'h1;
  localparam logic [3:0] WORD_MODE = 4'h3;
  localparam logic [3:0] WORD_EQADDR = 4'h8;
  localparam logic [3:0] WORD_OPADDR = 4'h9;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_FREQ = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam int MODE_W = 10;
  localparam int FREQ_W = 22;
  localparam logic [9:0] MODE_RST = 10'h200;
  localparam logic [21:0] FREQ_RST = 22'h000000;
  localparam int MF_STATE = 0;
  localparam int MF_POWER = 2;
  localparam int MF_SEL = 3;
  localparam int MF_STBY = 6;
  localparam int MF_EHT = 7;
  localparam int MF_RESET = 8;
  localparam int MF_AUTO = 9;
  localparam int SF_FAULT = 0;
  localparam int SF_EXT = 1;
  localparam int SF_OPADDR = 2;
  localparam int SF_USER = 4;
  localparam int SF_WID = 8;
  typedef enum logic [1:0] {TX_OPERATE, TX_MUTE, TX_TRANSMIT} tcwl_txst_e;
  typedef enum logic [2:0] {
    MS_KEYED, MS_AM_REDUCED, MS_USB20, MS_USB_SUPP,
    MS_LSB20, MS_LSB_SUPP, MS_INDEP20, MS_INDEP_SUPP
  } tcwl_msel_e;
endpackage : tcwl_pkg

// ---- design/tcwl_sync.sv ----
`timescale 1ns/10ps
module tcwl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic ff1;
  logic ff2;
  logic ff3;
  logic agree;

  // A change is only believed once the second and third stages agree.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
      o_level <= RST_VAL;
    end
    else
    begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
      if (agree)
      begin
        o_level <= ff3;
      end
    end
  end

  assign agree = (ff2 == ff3);
  assign o_rise = agree & ff3 & ~o_level;
  assign o_fall = agree & ~ff3 & o_level;
endmodule : tcwl_sync

// ---- dv/tcwl_far_end.sv ----
`timescale 1ns/10ps
// -------------------------
// Far-end transmitter model.
// -------------------------
module tcwl_far_end (
  input wire logic i_ctl_clk,
  input wire logic i_ctl_data,
  input wire logic i_noise,
  input wire logic i_op_call,
  input wire logic [3:0] i_user,
  output logic o_rev_clk,
  output logic o_rev_data,
  output logic [47:0] o_fwd,
  output int o_nfwd
);
  logic [47:0] fr = '0;
  logic [47:0] prev = '0;
  logic [47:0] s;
  logic [47:0] q[$];
  int n = -1;
  int fails = 0;
  initial o_rev_clk = 1'b0;
  initial o_rev_data = 1'b1;
  initial o_nfwd = 0;
  function automatic logic [47:0] mon(input logic f);
    mon = '0;
    mon[5:0] = tcwl_pkg::SYNC_CODE;
    mon[19:16] = i_user;
    mon[34] = f;
  endfunction : mon
  always @(posedge i_ctl_clk)
  begin
    fr = {i_ctl_data, fr[47:1]};
    if (n >= 0)
      n++;
    else if (fr[47:42] == tcwl_pkg::SYNC_CODE)
      n = 6;
    if (n == 48)
    begin
      n = -1;
      o_fwd = fr;
      o_nfwd++;
      if (fr[8] && !fr[9])
        q.push_back(fr);
      else if (fr == prev)
      begin
        fails = 0;
        q.push_back(fr[15:12] == 4'h0 ? mon(1'b0) : fr);
      end
      else
      begin
        fails++;
        q.push_back(mon(fails >= 3));
      end
      // one operator address word on request
      if (i_op_call)
        q.push_back(mon(1'b0) | 48'h9000);
      // Line noise spoils the next comparison.
      prev = i_noise ? ~fr : fr;
    end
  end
  initial
  forever
  begin
    wait (q.size() != 0);
    s = q.pop_front();
    for (int i = 0; i < 48; i++)
    begin
      o_rev_data = s[i];
      #80 o_rev_clk = 1'b1;
      #80 o_rev_clk = 1'b0;
    end
    // A released line must not look like a held bit.
    o_rev_data = ~s[47];
  end
endmodule : tcwl_far_end

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
// ---------------------
// Link block testbench.
// ---------------------
module testbench;
  localparam logic [6:0] MT [8] = '{7'h48, 7'h01, 7'h04, 7'h00, 7'h0c, 7'h08, 7'h14, 7'h10};
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, mck = 1'b0, run_ext = 1'b1;
  logic noise = 1'b0, op = 1'b0, wreq, cclk, cdat, rclk, rdata, lfault;
  logic [3:0] adr = 4'h0, earth_n = 4'hf, ruser_n;
  logic [31:0] wdat = 32'h0, rdat;
  logic [47:0] fwd;
  int nfwd, n_errors = 0, n_compared = 0;
  always #10 clk = ~clk;
  // master clock, far faster than real to keep the run short
  always #80 mck = run_ext & ~mck;
  tcwl_link #(.EXT_LOSS_CYC(200)) u_dut (.i_mclk(clk), .i_arst_n(rst_n), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wdat), .i_byteenable(4'hf), .o_readdata(rdat),
    .o_waitrequest(wreq), .i_master_clk(mck), .i_rev_clk(rclk), .i_rev_data(rdata),
    .o_ctl_clk(cclk), .o_ctl_data(cdat), .i_user_earth_n(earth_n), .o_rev_user_n(ruser_n),
    .o_line_fault(lfault));
  tcwl_far_end u_far (.i_ctl_clk(cclk), .i_ctl_data(cdat), .i_noise(noise), .i_op_call(op),
    .i_user(4'h6), .o_rev_clk(rclk), .o_rev_data(rdata), .o_fwd(fwd), .o_nfwd(nfwd));
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 99);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (k == 99)
    begin
      chk("bus", 0, 1);
      end_sim();
    end
  endtask : bus
  task automatic frm(input int after, output logic [47:0] f);
    int k;
    k = 0;
    while (nfwd < after && k < 9999)
    begin
      @(posedge clk);
      k++;
    end
    f = fwd;
    if (k == 9999)
    begin
      chk("frame", 0, 1);
      end_sim();
    end
  endtask : frm
  task automatic rise(output int k);
    logic c0;
    c0 = 1'b1;
    for (k = 1; k < 9000; k++)
    begin
      @(posedge clk);
      if (cclk === 1'b1 && c0 === 1'b0)
        break;
      c0 = cclk;
    end
    if (k == 9000)
    begin
      chk("rise", 0, 1);
      end_sim();
    end
  endtask : rise
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, tcwl_pkg::REG_MODE, 32'h0, q);
    chk("mode", 32'h200, q);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 0, q);
    bus(1'b0, tcwl_pkg::REG_STAT, 32'h0, q);
    chk("ext", 1, q[1]);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mode();
    logic [47:0] f;
    logic [1:0] st;
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      st = 2'(i % 3);
      earth_n <= 4'(i) ^ 4'h5;
      bus(1'b1, tcwl_pkg::REG_MODE, {22'h0, 1'b1, 3'h0, 3'(i), i[0], st}, f[31:0]);
      frm(nfwd + 3, f);
      for (int j = 0; j < 6 && f[15:12] !== 4'h3; j++)
        frm(nfwd + 1, f);
      chk("state", st, f[34:33]);
      chk("power", i[0], f[36]);
      chk("carrier", MT[i][2:0], f[27:25]);
      chk("sideband", MT[i][6:3], f[31:28]);
      chk("user", 4'(i) ^ 4'ha, f[47:44]);
      chk("ident", 4'h3, f[15:12]);
      chk("sync", tcwl_pkg::SYNC_CODE, f[5:0]);
      r = 1'b0;
      for (int j = 6; j < 44; j++)
        r = r | (&f[j+:5]);
      chk("run", 0, r);
    end
    $display("test mode done");
  endtask : t_mode
  task automatic t_fault();
    logic [47:0] f;
    frm(nfwd + 4, f);
    chk("fault", 0, lfault);
    chk("ruser", 4'h9, ruser_n);
    noise <= 1'b1;
    frm(nfwd + 8, f);
    chk("fault", 1, lfault);
    noise <= 1'b0;
    frm(nfwd + 8, f);
    chk("fault", 0, lfault);
    $display("test fault done");
  endtask : t_fault
  task automatic t_addr();
    logic [47:0] f;
    logic [31:0] q;
    op <= 1'b1;
    frm(nfwd + 1, f);
    op <= 1'b0;
    frm(nfwd + 5, f);
    bus(1'b0, tcwl_pkg::REG_STAT, 32'h0, q);
    chk("opaddr", 1, q[2]);
    bus(1'b1, tcwl_pkg::REG_STAT, 32'h4, q);
    bus(1'b0, tcwl_pkg::REG_STAT, 32'h0, q);
    chk("opclr", 0, q[2]);
    $display("test addr done");
  endtask : t_addr
  task automatic t_check();
    logic [47:0] f;
    logic [3:0] p;
    bus(1'b1, tcwl_pkg::REG_CTRL, 32'h1, f[31:0]);
    bus(1'b1, tcwl_pkg::REG_MODE, 32'h200, f[31:0]);
    bus(1'b0, tcwl_pkg::REG_MODE, 32'h0, f[31:0]);
    chk("frozen", 32'h23d, f[31:0]);
    frm(nfwd + 3, f);
    chk("inhibit", 1, f[8]);
    noise <= 1'b1;
    p = f[15:12];
    repeat (8)
    begin
      frm(nfwd + 1, f);
      if (f[15:12] !== p)
        chk("order", p == 4'h0 ? 4'h1 : (p == 4'h1 ? 4'h3 : 4'h0), f[15:12]);
      p = f[15:12];
    end
    chk("fault", 0, lfault);
    noise <= 1'b0;
    frm(nfwd + 2, f);
    bus(1'b1, tcwl_pkg::REG_CTRL, 32'h0, f[31:0]);
    $display("test check done");
  endtask : t_check
  task automatic t_clk();
    logic [31:0] q;
    int k;
    run_ext <= 1'b0;
    repeat (400) @(posedge clk);
    bus(1'b0, tcwl_pkg::REG_STAT, 32'h0, q);
    chk("ext", 0, q[1]);
    rise(k);
    rise(k);
    chk("period", 2 * tcwl_pkg::INT_HALF_CYC, k);
    run_ext <= 1'b1;
    repeat (40) @(posedge clk);
    bus(1'b0, tcwl_pkg::REG_STAT, 32'h0, q);
    chk("ext", 1, q[1]);
    $display("test clock done");
  endtask : t_clk
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_mode();
    t_fault();
    t_addr();
    t_check();
    t_clk();
    end_sim();
  end
endmodule : testbench
